// ==== core/lfsb_pkg.sv ====
// shared constants for the flash, safety and backlight control block
// assumes a single 10 MHz system clock and byte-wide registers over the serial port
package lfsb_pkg;

  // register offsets
  localparam logic [7:0] REG_COLOUR_CTRL = 8'h00;
  localparam logic [7:0] REG_SAFETY = 8'h01;
  localparam logic [7:0] REG_COLOUR_MAX = 8'h02;
  localparam logic [7:0] REG_BL_CTRL = 8'h03;
  localparam logic [7:0] REG_BL_PRI = 8'h04;
  localparam logic [7:0] REG_BL_SEC = 8'h05;
  localparam logic [7:0] REG_GPIO_CTRL = 8'h06;
  localparam logic [7:0] REG_BL_PWM = 8'h2b;

  // colour control field positions
  localparam int COL_BLK_EN_BIT = 0;
  localparam int COL_DIM_BIT = 1;
  localparam int COL_FLASH_BIT = 2;
  localparam int COL_SW_LSB = 4;
  // safety register field positions
  localparam int SAFE_EN_LSB = 0;
  localparam int SAFE_GATE_LSB = 4;
  localparam int SAFE_TRIP_BIT = 7;
  // backlight control field positions
  localparam int BL_SEC_EN_BIT = 0;
  localparam int BL_PRI_EN_BIT = 1;
  localparam int BL_JOIN_BIT = 2;
  localparam int BL_FADE_EN_BIT = 3;
  localparam int BL_FADE_SEL_BIT = 4;
  localparam int BL_SLOPE_BIT = 5;
  // gpio control and backlight gating
  localparam int GPIO_PWM_PIN_BIT = 4;
  localparam int BL_PWM_SEC_BIT = 0;
  localparam int BL_PWM_PRI_BIT = 1;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] CODE_FULL = 2'h3;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SAFETY_TIME_MS = 1000;
  localparam int SAFETY_CYCLES = SAFETY_TIME_MS * (CLK_HZ / 1000);
  localparam int FADE_SLOW_MS = 1300;
  localparam int FADE_FAST_MS = 650;
  localparam int FADE_STEPS = 255;
  localparam int FADE_SLOW_STEP_CYCLES = FADE_SLOW_MS * (CLK_HZ / 1000) / FADE_STEPS;
  localparam int FADE_FAST_STEP_CYCLES = FADE_FAST_MS * (CLK_HZ / 1000) / FADE_STEPS;

  // serial port slave address, value arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_ARMED = 2'b01,
    FL_FIRING = 2'b11,
    FL_SPENT = 2'b10
  } lfsb_flash_st_t;

  typedef enum logic [2:0] {
    I2_IDLE = 3'b000,
    I2_DEV = 3'b001,
    I2_REG = 3'b011,
    I2_WR = 3'b010,
    I2_RD = 3'b110
  } lfsb_i2c_st_t;

endpackage

// ==== core/lfsb_i2c_slave.sv ====
// serial register port: start, address byte, pointer byte, data bytes
// assumes scl and sda already synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module lfsb_i2c_slave
  import lfsb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic wr_o,
  output logic acc_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rdata_i
);
  lfsb_i2c_st_t st_q;
  logic scl_q, sda_q, ack_q, mack_q, nack_q;
  logic [7:0] sh_q, tx_q, ptr_q;
  logic [3:0] bit_q;
  logic rise, fall, start, stop;

  assign rise = scl_i & ~scl_q;
  assign fall = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop = scl_i & scl_q & ~sda_q & sda_i;
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_q | ((st_q == I2_RD) & ~mack_q & ~tx_q[7]);
  assign rd_addr_o = ptr_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= I2_IDLE;
      ack_q <= 1'b0;
      mack_q <= 1'b0;
      nack_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      ptr_q <= 8'h00;
      bit_q <= 4'h0;
      wr_o <= 1'b0;
      acc_o <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      acc_o <= 1'b0;
      if (start) begin
        st_q <= I2_DEV;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        mack_q <= 1'b0;
        tx_q <= 8'hff;
      end else if (stop) begin
        st_q <= I2_IDLE;
        ack_q <= 1'b0;
        mack_q <= 1'b0;
        tx_q <= 8'hff;
      end else if (rise && st_q != I2_IDLE) begin
        if (mack_q) begin
          nack_q <= sda_i;
        end else if (!ack_q) begin
          sh_q <= {sh_q[6:0], sda_i};
          bit_q <= bit_q + 4'h1;
        end
      end else if (fall && st_q != I2_IDLE) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          bit_q <= 4'h0;
          if (st_q == I2_RD) begin
            tx_q <= rdata_i;
            acc_o <= 1'b1;
            addr_o <= ptr_q;
          end
        end else if (mack_q) begin
          mack_q <= 1'b0;
          bit_q <= 4'h0;
          if (nack_q) begin
            st_q <= I2_IDLE;
            tx_q <= 8'hff;
          end else begin
            tx_q <= rdata_i;
            acc_o <= 1'b1;
            addr_o <= ptr_q;
          end
        end else if (bit_q == 4'h8) begin
          case (st_q)
            I2_DEV: begin
              if (sh_q[7:1] == I2C_DEV_ADDR) begin
                ack_q <= 1'b1;
                st_q <= sh_q[0] ? I2_RD : I2_REG;
              end else begin
                st_q <= I2_IDLE;
              end
            end
            I2_REG: begin
              ptr_q <= sh_q;
              ack_q <= 1'b1;
              st_q <= I2_WR;
            end
            I2_WR: begin
              wdata_o <= sh_q;
              addr_o <= ptr_q;
              wr_o <= 1'b1;
              acc_o <= 1'b1;
              ack_q <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
            end
            I2_RD: begin
              mack_q <= 1'b1;
              tx_q <= 8'hff;
              ptr_q <= ptr_q + 8'h01;
            end
            default: begin
              st_q <= I2_IDLE;
            end
          endcase
        end else if (st_q == I2_RD) begin
          tx_q <= {tx_q[6:0], 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/lfsb_fade.sv ====
// one backlight fade channel: walks the level one code per step tick
// assumes the step tick is a one-cycle enable at the selected slope rate
`timescale 1ns/1ps
`default_nettype none
module lfsb_fade
  import lfsb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] target_i,
  input wire logic fade_en_i,
  input wire logic step_i,
  output logic [7:0] level_o
);
  // fixed rate per code gives shorter times for partial changes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_o <= REG_RESET;
    end else if (!fade_en_i) begin
      level_o <= target_i;
    end else if (step_i && level_o < target_i) begin
      level_o <= level_o + 8'h01;
    end else if (step_i && level_o > target_i) begin
      level_o <= level_o - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== core/lfsb_top.sv ====
// What this block does
// - pre-flash follows current code and on switch
// - flash pulse forces selected sinks to full current
// - trigger falling edge switches flash sinks off
// - one flash per arm; re-arm by toggling enable
// - per-colour safety enables; mode from flash enable
// - normal mode counts; 02H access restarts counter
// - one second trips safety, cuts enabled sinks
// - flash mode counts only while trigger high
// - clearing own safety bit restores the sink
// - trip cleared only with all safety bits off
// - backlight codes are 8-bit, 0.1 mA steps
// - primary code at 04H, secondary at 05H
// - joined display drives both from primary code
// - control bits 1 and 0 enable sinks
// - external gate passes sink only while pin high
// - fade ramps; slope bit picks 1.3s or 0.65s
// - partial fades take proportionally less time
// - fade select picks sink; joined with select 0 fades both
// - gpio control bit 4 makes pin 0 the trigger
// - 02H holds three 2-bit quarter-step colour codes
//
// top of the lighting control: registers, flash sequencer, safety timer, backlight
// assumes the trigger/pwm pin and the serial lines are synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module lfsb_top
  import lfsb_pkg::*;
#(
  parameter int SAFETY_CYCLES_P = SAFETY_CYCLES,
  parameter int SLOW_STEP_P = FADE_SLOW_STEP_CYCLES,
  parameter int FAST_STEP_P = FADE_FAST_STEP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic pwm_pin_i,
  output logic [2:0] colour_on_o,
  output logic [5:0] colour_code_o,
  output logic [1:0] bl_on_o,
  output logic [15:0] bl_code_o,
  output logic safety_tripped_o
);
  logic wr, acc;
  logic [7:0] addr, wdata, rd_addr;
  logic [7:0] rdata;
  logic [7:0] col_ctrl_q, safety_q, max_q, bl_ctrl_q, pri_q, sec_q, gpio_q, bl_pwm_q;
  logic tripped_q, pin_q;
  logic [23:0] sc_q;
  logic [15:0] div_q;
  logic step;
  lfsb_flash_st_t fl_q;
  logic [7:0] lvl_pri, lvl_sec;

  logic blk_en, flash_en, pwm_pin_en, joined, fade_en, fade_sel, slope;
  logic [2:0] sw, safe_en, gate;
  logic acc02, pin_rise, pin_fall;

  assign blk_en = col_ctrl_q[COL_BLK_EN_BIT];
  assign flash_en = col_ctrl_q[COL_FLASH_BIT];
  assign sw = col_ctrl_q[COL_SW_LSB +: 3];
  assign safe_en = safety_q[SAFE_EN_LSB +: 3];
  assign gate = safety_q[SAFE_GATE_LSB +: 3];
  assign pwm_pin_en = gpio_q[GPIO_PWM_PIN_BIT];
  assign joined = bl_ctrl_q[BL_JOIN_BIT];
  assign fade_en = bl_ctrl_q[BL_FADE_EN_BIT];
  assign fade_sel = bl_ctrl_q[BL_FADE_SEL_BIT];
  assign slope = bl_ctrl_q[BL_SLOPE_BIT];
  assign acc02 = acc && (addr == REG_COLOUR_MAX);
  // trigger pin only counts when routed as the pwm input
  assign pin_rise = pwm_pin_en & pwm_pin_i & ~pin_q;
  assign pin_fall = pwm_pin_en & ~pwm_pin_i & pin_q;
  assign safety_tripped_o = tripped_q;

  lfsb_i2c_slave u_port (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr),
    .acc_o(acc),
    .addr_o(addr),
    .wdata_o(wdata),
    .rd_addr_o(rd_addr),
    .rdata_i(rdata)
  );

  // register file
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      col_ctrl_q <= REG_RESET;
      safety_q <= REG_RESET;
      max_q <= REG_RESET;
      bl_ctrl_q <= REG_RESET;
      pri_q <= REG_RESET;
      sec_q <= REG_RESET;
      gpio_q <= REG_RESET;
      bl_pwm_q <= REG_RESET;
    end else if (wr) begin
      case (addr)
        REG_COLOUR_CTRL: col_ctrl_q <= wdata & 8'h77;
        REG_SAFETY: safety_q <= wdata & 8'h77;
        REG_COLOUR_MAX: max_q <= wdata & 8'h3f;
        REG_BL_CTRL: bl_ctrl_q <= wdata & 8'h3f;
        REG_BL_PRI: pri_q <= wdata;
        REG_BL_SEC: sec_q <= wdata;
        REG_GPIO_CTRL: gpio_q <= wdata & 8'h17;
        REG_BL_PWM: bl_pwm_q <= wdata & 8'h03;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (rd_addr)
      REG_COLOUR_CTRL: rdata = col_ctrl_q;
      REG_SAFETY: rdata = safety_q | {tripped_q, 7'h00};
      REG_COLOUR_MAX: rdata = max_q;
      REG_BL_CTRL: rdata = bl_ctrl_q;
      REG_BL_PRI: rdata = pri_q;
      REG_BL_SEC: rdata = sec_q;
      REG_GPIO_CTRL: rdata = gpio_q;
      REG_BL_PWM: rdata = bl_pwm_q;
      default: rdata = 8'h00;
    endcase
  end

  // flash sequencer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pwm_pin_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fl_q <= FL_IDLE;
    end else if (!flash_en) begin
      fl_q <= FL_IDLE;
    end else begin
      case (fl_q)
        // arming waits for a low trigger so a stuck-high pin cannot fire
        FL_IDLE: if (!pwm_pin_i) fl_q <= FL_ARMED;
        FL_ARMED: if (pin_rise) fl_q <= FL_FIRING;
        FL_FIRING: if (pin_fall) fl_q <= FL_SPENT;
        FL_SPENT: fl_q <= FL_SPENT;
        default: fl_q <= FL_IDLE;
      endcase
    end
  end

  // safety timer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sc_q <= 24'h000000;
      tripped_q <= 1'b0;
    end else if (safe_en == 3'h0) begin
      sc_q <= 24'h000000;
      tripped_q <= 1'b0;
    end else if (tripped_q) begin
      sc_q <= sc_q;
    end else if (!flash_en && acc02) begin
      sc_q <= 24'h000000;
    end else if (flash_en && !(pwm_pin_en && pwm_pin_i)) begin
      sc_q <= 24'h000000;
    end else if (sc_q == 24'(SAFETY_CYCLES_P - 1)) begin
      tripped_q <= 1'b1;
    end else begin
      sc_q <= sc_q + 24'h000001;
    end
  end

  // colour sinks
  wire [2:0] on_d;
  wire [5:0] code_d;
  for (genvar i = 0; i < 3; i++) begin : g_colour
    logic on;
    logic [1:0] code;
    always_comb begin
      code = max_q[2*i +: 2];
      on = blk_en & sw[i];
      if (!flash_en && pwm_pin_en && gate[i]) begin
        on = on & pwm_pin_i;
      end
      if (flash_en && gate[i]) begin
        if (fl_q == FL_FIRING) begin
          on = blk_en;
          code = CODE_FULL;
        end else if (fl_q == FL_SPENT) begin
          on = 1'b0;
        end
      end
      // only this sink's own enable gates the cut, so clearing it restores the sink
      if (tripped_q && safe_en[i]) begin
        on = 1'b0;
      end
    end
    assign on_d[i] = on;
    assign code_d[2*i +: 2] = code;

    property p_flash_full;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (fl_q == FL_FIRING && flash_en && gate[i] && blk_en && !(tripped_q && safe_en[i]))
      |=> (colour_on_o[i] && colour_code_o[2*i +: 2] == CODE_FULL);
    endproperty
    a_flash_full: assert property (p_flash_full) else $error("flash sink not at full");

    property p_safety_cut;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (tripped_q && safe_en[i]) |=> !colour_on_o[i];
    endproperty
    a_safety_cut: assert property (p_safety_cut) else $error("tripped sink still on");
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      colour_on_o <= 3'h0;
      colour_code_o <= 6'h00;
    end else begin
      colour_on_o <= on_d;
      colour_code_o <= code_d;
    end
  end

  // fade step divider, one code per tick
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 16'h0000;
      step <= 1'b0;
    end else if (div_q >= (slope ? 16'(FAST_STEP_P - 1) : 16'(SLOW_STEP_P - 1))) begin
      div_q <= 16'h0000;
      step <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      step <= 1'b0;
    end
  end

  lfsb_fade u_fade_pri (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .target_i(pri_q),
    .fade_en_i(fade_en & ~fade_sel),
    .step_i(step),
    .level_o(lvl_pri)
  );

  lfsb_fade u_fade_sec (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .target_i(joined ? pri_q : sec_q),
    .fade_en_i(fade_en & (fade_sel | joined)),
    .step_i(step),
    .level_o(lvl_sec)
  );

  // backlight outputs; code maps straight to 0.1 mA per step
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bl_on_o <= 2'h0;
      bl_code_o <= 16'h0000;
    end else begin
      bl_code_o <= {lvl_sec, lvl_pri};
      bl_on_o[0] <= bl_ctrl_q[BL_PRI_EN_BIT] &
        (!(bl_pwm_q[BL_PWM_PRI_BIT] && pwm_pin_en) || pwm_pin_i);
      bl_on_o[1] <= bl_ctrl_q[BL_SEC_EN_BIT] &
        (!(bl_pwm_q[BL_PWM_SEC_BIT] && pwm_pin_en) || pwm_pin_i);
    end
  end

  property p_rearm;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (fl_q == FL_SPENT && flash_en) |=> (fl_q == FL_SPENT) || !$past(flash_en);
  endproperty
  a_rearm: assert property (p_rearm) else $error("flash re-armed without toggle");

  property p_fall_ends;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (fl_q == FL_FIRING && flash_en && pin_fall) |=> (fl_q == FL_SPENT || !flash_en);
  endproperty
  a_fall_ends: assert property (p_fall_ends) else $error("falling edge did not end flash");

  property p_trip_sticky;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (tripped_q && safe_en != 3'h0) |=> tripped_q;
  endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("trip cleared early");

  property p_restart;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (!flash_en && acc02 && !tripped_q && safe_en != 3'h0) |=> (sc_q == 24'h000000);
  endproperty
  a_restart: assert property (p_restart) else $error("02H access did not restart");

  property p_flash_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (flash_en && !pwm_pin_i && !tripped_q) |=> (sc_q == 24'h000000);
  endproperty
  a_flash_hold: assert property (p_flash_hold) else $error("counted with trigger low");

  property p_joined;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (joined && !fade_en) [*2] |=> (bl_code_o[15:8] == bl_code_o[7:0]);
  endproperty
  a_joined: assert property (p_joined) else $error("joined sinks differ");

  property p_bl_enable;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !bl_ctrl_q[BL_PRI_EN_BIT] |=> !bl_on_o[0];
  endproperty
  a_bl_enable: assert property (p_bl_enable) else $error("disabled sink on");

  property p_fade_step;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (fade_en && !fade_sel && $stable(bl_ctrl_q) && !step) |=> $stable(lvl_pri);
  endproperty
  a_fade_step: assert property (p_fade_step) else $error("fade moved off tick");
endmodule
`default_nettype wire

// ==== tb/lfsb_host_model.sv ====
// host model: serial register master plus trigger/pwm pin driver
// assumes open-drain sda with pull-up; the device pulls low through sda_oe_i
`timescale 1ns/1ps
`default_nettype none
module lfsb_host_model
  import lfsb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o,
  output logic pwm_o
);
  logic sda_m = 1'b1;
  logic nack_seen = 1'b0;
  initial begin
    scl_o = 1'b1;
    pwm_o = 1'b0;
  end
  // pull-up: released line reads high
  assign sda_o = sda_m & ~sda_oe_i;
  task automatic t(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // sda only moves while scl is low; phases of 4 clk keep the 3 clk minimum
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    t(4);
    scl_o = 1'b1;
    t(4);
    r = sda_o;
    scl_o = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b1;
    t(4);
    scl_o = 1'b1;
    t(4);
    sda_m = 1'b0;
    t(4);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    t(4);
    scl_o = 1'b1;
    t(4);
    sda_m = 1'b1;
    t(4);
  endtask
  task automatic tx(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    if (r !== 1'b0) nack_seen = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({I2C_DEV_ADDR, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    tx({I2C_DEV_ADDR, 1'b0});
    tx(a);
    start();
    tx({I2C_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
    stop();
  endtask
  // trigger stays low until the host means to fire
  task automatic pin(input logic v);
    pwm_o = v;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: reset checks, table of backlight cases, then fade, gating, flash and safety tests
// assumes the host model as the only driver of the serial lines and the pin
`timescale 1ns/1ps
`default_nettype none
module tb
  import lfsb_pkg::*;
;
  localparam int SAFE = 2000;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda, pwm, sda_oe, tripped, sda_dout;
  logic [2:0] c_on;
  logic [5:0] c_code;
  logic [1:0] bl_on;
  logic [15:0] bl_code;
  logic [7:0] d;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pri;
    logic [7:0] sec;
    logic [1:0] on;
    logic [15:0] code;
    logic [1:0] m;
  } lfsb_row_t;
  lfsb_row_t rows [6] = '{
    '{8'h03, 8'h12, 8'h34, 2'h3, 16'h3412, 2'h3},
    '{8'h07, 8'h12, 8'h34, 2'h3, 16'h1212, 2'h3},
    '{8'h02, 8'h56, 8'h78, 2'h1, 16'h7856, 2'h1},
    '{8'h01, 8'h56, 8'h78, 2'h2, 16'h7856, 2'h1},
    '{8'h03, 8'h00, 8'hff, 2'h0, 16'hff00, 2'h2},
    '{8'h07, 8'hff, 8'h00, 2'h3, 16'hffff, 2'h3}
  };
  lfsb_top #(.SAFETY_CYCLES_P(SAFE), .SLOW_STEP_P(SLOW), .FAST_STEP_P(FAST)) lfsb_top_inst (
    .clk_sys_i(clk), .arst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_dout),
    .sda_oe_o(sda_oe), .pwm_pin_i(pwm), .colour_on_o(c_on), .colour_code_o(c_code),
    .bl_on_o(bl_on), .bl_code_o(bl_code), .safety_tripped_o(tripped));
  lfsb_host_model lfsb_host_model_inst (
    .clk_sys_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda), .pwm_o(pwm));
  initial forever #50 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    lfsb_host_model_inst.wr(a, v);
    cyc(4);
  endtask
  task automatic r(input logic [7:0] a, output logic [7:0] v);
    lfsb_host_model_inst.rd(a, v);
  endtask
  // single call site keeps the trigger level a variable at the model boundary
  task automatic trig(input logic v);
    lfsb_host_model_inst.pin(v);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fin(input string s);
    $display("test %s done, compares=%0d errors=%0d", s, compares, error_cnt);
  endtask
  task automatic close_out();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // fade must move one code at a time and land inside the cycle window
  task automatic fade(input logic [7:0] ctrl, a, v, input int sh, lo, hi);
    logic [7:0] prev, cur;
    int n;
    w(REG_BL_CTRL, ctrl);
    w(a, v);
    n = 0;
    cur = 8'(bl_code >> sh);
    while (cur !== v && n < 400) begin
      prev = cur;
      cyc(1);
      cur = 8'(bl_code >> sh);
      if (cur !== prev && cur !== prev + 8'h1 && cur !== prev - 8'h1) chk(16'(cur), 16'(prev));
      n++;
    end
    chk(16'(cur), 16'(v));
    chk(16'(n >= lo && n <= hi), 16'h1);
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(2);
    chk(16'({c_on, c_code, bl_on, tripped}), 16'h0);
    chk(bl_code, 16'h0);
    chk(16'({sda_dout, sda_oe}), 16'h0);
    r(REG_BL_CTRL, d);
    chk(16'(d), 16'h0);
    r(REG_BL_SEC, d);
    chk(16'(d), 16'h0);
    r(8'h40, d);
    chk(16'(d), 16'h0);
    fin("reset");
    foreach (rows[i]) begin
      w(REG_BL_CTRL, rows[i].ctrl);
      w(REG_BL_PRI, rows[i].pri);
      w(REG_BL_SEC, rows[i].sec);
      if (rows[i].m[0]) chk(16'(bl_on), 16'(rows[i].on));
      if (rows[i].m[1]) chk(bl_code, rows[i].code);
      r(REG_BL_PRI, d);
      chk(16'(d), 16'(rows[i].pri));
    end
    fin("table");
    w(REG_BL_PRI, 8'h00);
    w(REG_BL_SEC, 8'h00);
    // slope, select and fade set before the new code
    fade(8'h0b, REG_BL_PRI, 8'h10, 0, 80, 136);
    fade(8'h2b, REG_BL_PRI, 8'h00, 0, 20, 68);
    fade(8'h1b, REG_BL_SEC, 8'h08, 8, 24, 68);
    fade(8'h0f, REG_BL_PRI, 8'h18, 8, 144, 200);
    fin("fade");
    w(REG_BL_CTRL, 8'h03);
    w(REG_GPIO_CTRL, 8'h10);
    w(REG_BL_PWM, 8'h03);
    chk(16'(bl_on), 16'h0);
    trig(1'b1);
    cyc(4);
    chk(16'(bl_on), 16'h3);
    w(REG_GPIO_CTRL, 8'h00);
    trig(1'b0);
    cyc(4);
    chk(16'(bl_on), 16'h3);
    w(REG_BL_PWM, 8'h00);
    fin("gating");
    // outside flash mode a gated colour sink follows the pin level
    w(REG_COLOUR_MAX, 8'h1b);
    w(REG_COLOUR_CTRL, 8'h71);
    w(REG_GPIO_CTRL, 8'h10);
    w(REG_SAFETY, 8'h40);
    chk(16'(c_on), 16'h3);
    trig(1'b1);
    cyc(4);
    chk(16'(c_on), 16'h7);
    trig(1'b0);
    w(REG_COLOUR_CTRL, 8'h75);
    w(REG_SAFETY, 8'h70);
    chk(16'(c_on), 16'h7);
    chk(16'(c_code), 16'h1b);
    trig(1'b1);
    cyc(4);
    chk(16'({c_on, c_code}), 16'({3'h7, 6'h3f}));
    trig(1'b0);
    cyc(4);
    chk(16'(c_on), 16'h0);
    trig(1'b1);
    cyc(4);
    chk(16'(c_on), 16'h0);
    trig(1'b0);
    w(REG_COLOUR_CTRL, 8'h71);
    w(REG_COLOUR_CTRL, 8'h75);
    trig(1'b1);
    cyc(4);
    chk(16'(c_code), 16'h3f);
    trig(1'b0);
    fin("flash");
    w(REG_COLOUR_CTRL, 8'h71);
    w(REG_COLOUR_CTRL, 8'h75);
    w(REG_SAFETY, 8'h77);
    trig(1'b1);
    cyc(SAFE - 100);
    chk(16'(tripped), 16'h0);
    cyc(110);
    chk(16'({c_on, tripped}), 16'h1);
    trig(1'b0);
    w(REG_SAFETY, 8'h70);
    chk(16'(tripped), 16'h0);
    fin("flash safety");
    w(REG_COLOUR_CTRL, 8'h71);
    w(REG_SAFETY, 8'h07);
    chk(16'(c_on), 16'h7);
    repeat (3) begin
      cyc(1200);
      r(REG_COLOUR_MAX, d);
      chk(16'(d), 16'h1b);
    end
    chk(16'(tripped), 16'h0);
    cyc(SAFE + 10);
    chk(16'({c_on, tripped}), 16'h1);
    r(REG_COLOUR_MAX, d);
    chk(16'(tripped), 16'h1);
    w(REG_SAFETY, 8'h03);
    chk(16'({c_on, tripped}), 16'h9);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    chk(16'({c_on, tripped}), 16'h0);
    chk(16'(lfsb_host_model_inst.nack_seen), 16'h0);
    fin("safety");
    close_out();
  end
endmodule
`default_nettype wire
